// ===== common/secure_gate_defines.svh
`ifndef SECURE_GATE_DEFINES_SVH
`define SECURE_GATE_DEFINES_SVH

// Register offsets on the plain register port.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_WORDS 8'h08

// Control register fields.
`define CTRL_START_BIT 0
`define CTRL_CLR_BIT 1

// Status register field positions.
`define ST_STATE_LSB 0
`define ST_ENC_BIT 4
`define ST_AUTH_BIT 5
`define ST_USER_BIT 6
`define ST_FAIL_BIT 7
`define ST_TAGERR_BIT 8
`define ST_SIGERR_BIT 9
`define ST_CMPERR_BIT 10
`define ST_LOCK_BIT 11
`define ST_DENY_BIT 12

// Bitstream header word fields.
`define HDR_ENC_BIT 0
`define HDR_AUTH_BIT 1
`define HDR_CMP_BIT 2
`define HDR_LEN_LSB 8

// Test-port instruction codes that stay open when locked.
`define JTAG_OP_IDCODE 8'h03
`define JTAG_OP_HEALTH 8'h05
`define JTAG_OP_BYPASS 8'hFF

// Restart pin least low time.
`define CLK_PERIOD_NS 20
`define RESTART_LOW_TIME_NS 1000
`define RESTART_LOW_CYC \
   ((`RESTART_LOW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== common/secure_gate_pkg.sv
package secure_gate_pkg;

   typedef enum logic [2:0] {
      S_IDLE,
      S_HEADER,
      S_PAYLOAD,
      S_TAG,
      S_SIG,
      S_DRAIN,
      S_USER,
      S_FAIL
   } cfg_state_t;

endpackage : secure_gate_pkg

// ===== common/crypt_if.sv
`timescale 1ns/100ps
interface crypt_if #(
   parameter int DW = 32
);
   logic in_valid;
   logic in_ready;
   logic [DW-1:0] in_data;
   logic dec_en;
   logic out_valid;
   logic out_ready;
   logic [DW-1:0] out_data;

   modport gate (
      output in_valid, in_data, dec_en, out_ready,
      input in_ready, out_valid, out_data
   );
   modport crypt (
      input in_valid, in_data, dec_en, out_ready,
      output in_ready, out_valid, out_data
   );
endinterface : crypt_if

// ===== verilog/stream_crypto.sv
`timescale 1ns/100ps
module stream_crypto import secure_gate_pkg::*; #(
   parameter int DW = 32
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Stream path to the gate.
   crypt_if.crypt cif,
   // Keystream from the block cipher counter engine.
   input wire logic ks_valid,
   input wire logic [DW-1:0] ks_word,
   output logic ks_take
);
   logic full_q, full_d;
   logic [DW-1:0] data_q, data_d;
   logic space;
   logic take;

   // A word waits while decryption is on and no keystream word is ready.
   always_comb begin
      space = !full_q || cif.out_ready;
      cif.in_ready = space && (!cif.dec_en || ks_valid);
      take = cif.in_valid && cif.in_ready;
      ks_take = take && cif.dec_en;
      full_d = full_q;
      data_d = data_q;
      if (full_q && cif.out_ready) begin
         full_d = 1'b0;
      end
      if (take) begin
         full_d = 1'b1;
         data_d = cif.dec_en ? (cif.in_data ^ ks_word) : cif.in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         full_q <= 1'b0;
         data_q <= '0;
      end else begin
         full_q <= full_d;
         data_q <= data_d;
      end
   end

   assign cif.out_valid = full_q;
   assign cif.out_data = data_q;
endmodule : stream_crypto

// ===== verilog/secure_config_gate.sv
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "secure_gate_defines.svh"
module secure_config_gate import secure_gate_pkg::*; #(
   parameter int DW = 32,
   parameter int IRW = 8,
   parameter int HW = 256
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Configuration restart pin.
   input wire logic cfg_restart_n,
   // Fuses.
   input wire logic [255:0] fuse_key,
   input wire logic [HW-1:0] fuse_key_hash,
   input wire logic fuse_jtag_lock,
   // Bitstream from flash.
   output logic flash_start,
   input wire logic bs_valid,
   input wire logic [DW-1:0] bs_data,
   output logic bs_ready,
   // Configuration memory write stream.
   output logic cram_valid,
   output logic [DW-1:0] cram_data,
   input wire logic cram_ready,
   output logic cram_abort,
   // Cipher engine.
   output logic [255:0] aes_key,
   input wire logic ks_valid,
   input wire logic [DW-1:0] ks_word,
   output logic ks_take,
   input wire logic tag_done,
   input wire logic tag_ok,
   // Signature engine.
   output logic feed_valid,
   output logic [DW-1:0] feed_data,
   output logic sig_start,
   input wire logic sig_done,
   input wire logic sig_ok,
   input wire logic [HW-1:0] sig_key_hash,
   // Test port instruction gate.
   input wire logic jtag_ir_upd,
   input wire logic [IRW-1:0] jtag_ir,
   output logic [IRW-1:0] jtag_ir_eff,
   output logic jtag_denied,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [31:0] reg_rdata,
   // Status.
   output logic user_mode,
   output logic cfg_fail
);
   localparam logic [7:0] LOW_CYC = 8'(`RESTART_LOW_CYC);

   crypt_if #(.DW(DW)) cif ();

   stream_crypto #(.DW(DW)) u_crypto (
      .clk(clk),
      .sys_rst(sys_rst),
      .cif(cif),
      .ks_valid(ks_valid),
      .ks_word(ks_word),
      .ks_take(ks_take)
   );

   cfg_state_t st_q, st_d;
   logic enc_q, enc_d, auth_q, auth_d;
   logic [DW-1:0] left_q, left_d, words_q, words_d;
   logic tagerr_q, tagerr_d, sigerr_q, sigerr_d, cmperr_q, cmperr_d;
   logic rst_pin_q, rst_pin_d;
   logic [7:0] low_q, low_d;
   logic fstart_q, fstart_d, sstart_q, sstart_d, abort_q, abort_d;
   logic fvalid_q, fvalid_d;
   logic [DW-1:0] fdata_q, fdata_d;
   logic go, take, sw_start, sw_clr, hdr_take;
   logic [DW-1:0] hdr_len;

   assign sw_start = reg_we && reg_addr == `REG_CTRL &&
                     reg_wdata[`CTRL_START_BIT];
   assign sw_clr = reg_we && reg_addr == `REG_CTRL &&
                   reg_wdata[`CTRL_CLR_BIT];
   assign hdr_len = DW'(bs_data[DW-1:`HDR_LEN_LSB]);
   // The source sees the start pulse only now, so a word still on the
   // bus from an earlier load must not be taken as the new header.
   assign hdr_take = st_q == S_HEADER && !fstart_q && bs_valid;

   // Payload enters the decrypt stage only while loading.
   assign cif.in_valid = st_q == S_PAYLOAD && bs_valid;
   assign cif.in_data = bs_data;
   assign cif.dec_en = enc_q;
   assign cif.out_ready = cram_ready;
   assign take = cif.in_valid && cif.in_ready;
   assign bs_ready = (st_q == S_HEADER && !fstart_q) ||
                     (st_q == S_PAYLOAD && cif.in_ready);

   always_comb begin
      st_d = st_q;
      enc_d = enc_q;
      auth_d = auth_q;
      left_d = left_q;
      words_d = words_q;
      tagerr_d = tagerr_q;
      sigerr_d = sigerr_q;
      cmperr_d = cmperr_q;
      fstart_d = 1'b0;
      sstart_d = 1'b0;
      abort_d = 1'b0;
      fvalid_d = take;
      fdata_d = take ? bs_data : fdata_q;
      rst_pin_d = cfg_restart_n;
      low_d = low_q;
      go = 1'b0;
      // Time the low phase; only a long enough pulse starts a load.
      if (!cfg_restart_n) begin
         if (low_q != LOW_CYC) begin
            low_d = low_q + 8'h01;
         end
      end else begin
         low_d = 8'h00;
      end
      if (!rst_pin_q && cfg_restart_n && low_q == LOW_CYC) begin
         go = 1'b1;
      end
      if (sw_start && st_q != S_USER) begin
         go = 1'b1;
      end
      if (sw_clr) begin
         tagerr_d = 1'b0;
         sigerr_d = 1'b0;
         cmperr_d = 1'b0;
      end
      case (st_q)
         S_HEADER: begin
            if (hdr_take) begin
               enc_d = bs_data[`HDR_ENC_BIT];
               auth_d = bs_data[`HDR_AUTH_BIT];
               words_d = '0;
               left_d = hdr_len;
               if (bs_data[`HDR_CMP_BIT] &&
                   (bs_data[`HDR_ENC_BIT] || bs_data[`HDR_AUTH_BIT])) begin
                  cmperr_d = 1'b1;
                  abort_d = 1'b1;
                  st_d = S_FAIL;
               end else if (hdr_len == '0) begin
                  st_d = S_DRAIN;
               end else begin
                  st_d = S_PAYLOAD;
               end
            end
         end
         S_PAYLOAD: begin
            if (take) begin
               left_d = left_q - DW'(1);
               words_d = words_q + DW'(1);
               if (left_q == DW'(1)) begin
                  if (enc_q) begin
                     st_d = S_TAG;
                  end else if (auth_q) begin
                     sstart_d = 1'b1;
                     st_d = S_SIG;
                  end else begin
                     st_d = S_DRAIN;
                  end
               end
            end
         end
         S_TAG: begin
            if (tag_done) begin
               if (!tag_ok) begin
                  tagerr_d = 1'b1;
                  abort_d = 1'b1;
                  st_d = S_FAIL;
               end else if (auth_q) begin
                  sstart_d = 1'b1;
                  st_d = S_SIG;
               end else begin
                  st_d = S_DRAIN;
               end
            end
         end
         S_SIG: begin
            if (sig_done) begin
               if (sig_ok && sig_key_hash == fuse_key_hash) begin
                  st_d = S_DRAIN;
               end else begin
                  sigerr_d = 1'b1;
                  abort_d = 1'b1;
                  st_d = S_FAIL;
               end
            end
         end
         S_DRAIN: begin
            if (!cif.out_valid) begin
               st_d = S_USER;
            end
         end
         S_IDLE, S_USER, S_FAIL: begin
         end
         default: begin
            st_d = S_IDLE;
         end
      endcase
      // A pin restart overrides any state, including a failed one; a software start overrides any state but S_USER.
      if (go) begin
         fstart_d = 1'b1;
         st_d = S_HEADER;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= S_IDLE;
         enc_q <= 1'b0;
         auth_q <= 1'b0;
         left_q <= '0;
         words_q <= '0;
         tagerr_q <= 1'b0;
         sigerr_q <= 1'b0;
         cmperr_q <= 1'b0;
         rst_pin_q <= 1'b1;
         low_q <= 8'h00;
         fstart_q <= 1'b0;
         sstart_q <= 1'b0;
         abort_q <= 1'b0;
         fvalid_q <= 1'b0;
         fdata_q <= '0;
      end else begin
         st_q <= st_d;
         enc_q <= enc_d;
         auth_q <= auth_d;
         left_q <= left_d;
         words_q <= words_d;
         tagerr_q <= tagerr_d;
         sigerr_q <= sigerr_d;
         cmperr_q <= cmperr_d;
         rst_pin_q <= rst_pin_d;
         low_q <= low_d;
         fstart_q <= fstart_d;
         sstart_q <= sstart_d;
         abort_q <= abort_d;
         fvalid_q <= fvalid_d;
         fdata_q <= fdata_d;
      end
   end

   // Only the data stage output reaches the configuration memory, and a
   // failed load drops whatever is still in flight.
   assign cram_valid = cif.out_valid && st_q != S_FAIL;
   assign cram_data = cif.out_data;
   assign cram_abort = abort_q;
   assign flash_start = fstart_q;
   assign sig_start = sstart_q;
   assign feed_valid = fvalid_q;
   assign feed_data = fdata_q;
   assign user_mode = st_q == S_USER;
   assign cfg_fail = st_q == S_FAIL;

   // Test port gate; the lock flag only ever sets.
   logic lock_q, lock_d, deny_q, deny_d, denied_q, denied_d;
   logic [IRW-1:0] ir_q, ir_d;
   logic [255:0] key_q;
   logic allowed;

   always_comb begin
      lock_d = lock_q || fuse_jtag_lock;
      allowed = jtag_ir == IRW'(`JTAG_OP_IDCODE) ||
                jtag_ir == IRW'(`JTAG_OP_HEALTH) ||
                jtag_ir == IRW'(`JTAG_OP_BYPASS);
      ir_d = ir_q;
      denied_d = 1'b0;
      deny_d = deny_q && !sw_clr;
      if (jtag_ir_upd) begin
         if ((lock_q || fuse_jtag_lock) && !allowed) begin
            ir_d = IRW'(`JTAG_OP_BYPASS);
            denied_d = 1'b1;
            deny_d = 1'b1;
         end else begin
            ir_d = jtag_ir;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lock_q <= 1'b0;
         deny_q <= 1'b0;
         denied_q <= 1'b0;
         ir_q <= IRW'(`JTAG_OP_BYPASS);
         key_q <= '0;
      end else begin
         lock_q <= lock_d;
         deny_q <= deny_d;
         denied_q <= denied_d;
         ir_q <= ir_d;
         key_q <= fuse_key;
      end
   end

   assign jtag_ir_eff = ir_q;
   assign jtag_denied = denied_q;
   assign aes_key = key_q;

   // Register read port, data one cycle after the strobe.
   logic [31:0] rd_q, rd_d, status;

   always_comb begin
      status = '0;
      status[`ST_STATE_LSB +: 3] = st_q;
      status[`ST_ENC_BIT] = enc_q;
      status[`ST_AUTH_BIT] = auth_q;
      status[`ST_USER_BIT] = st_q == S_USER;
      status[`ST_FAIL_BIT] = st_q == S_FAIL;
      status[`ST_TAGERR_BIT] = tagerr_q;
      status[`ST_SIGERR_BIT] = sigerr_q;
      status[`ST_CMPERR_BIT] = cmperr_q;
      status[`ST_LOCK_BIT] = lock_q;
      status[`ST_DENY_BIT] = deny_q;
      rd_d = '0;
      if (reg_re) begin
         case (reg_addr)
            `REG_STATUS: rd_d = status;
            `REG_WORDS: rd_d = 32'(words_q);
            default: rd_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_q <= '0;
      end else begin
         rd_q <= rd_d;
      end
   end

   assign reg_rdata = rd_q;
endmodule : secure_config_gate

// ===== tb/sg_chk.sv
`timescale 1ns/100ps
module sg_chk #(
   parameter int DW = 32,
   parameter int IRW = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Load path.
   input wire logic cfg_restart_n,
   input wire logic flash_start,
   input wire logic bs_valid,
   input wire logic [DW-1:0] bs_data,
   input wire logic bs_ready,
   input wire logic cram_valid,
   input wire logic cram_abort,
   input wire logic ks_valid,
   input wire logic ks_take,
   input wire logic feed_valid,
   input wire logic [DW-1:0] feed_data,
   // Test port.
   input wire logic fuse_jtag_lock,
   input wire logic jtag_ir_upd,
   input wire logic [IRW-1:0] jtag_ir,
   input wire logic [IRW-1:0] jtag_ir_eff,
   input wire logic jtag_denied,
   // Status.
   input wire logic user_mode,
   input wire logic cfg_fail
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic op_ok;
   assign op_ok = jtag_ir inside {8'h03, 8'h05, 8'hFF};
   property p_start;
      flash_start |-> $past(cfg_restart_n) && !$past(cfg_restart_n, 2);
   endproperty
   a_start: assert property (p_start) else $error("bad start");
   property p_excl;
      !(user_mode && cfg_fail);
   endproperty
   a_excl: assert property (p_excl) else $error("user and fail");
   property p_abort;
      $rose(cfg_fail) |-> cram_abort;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   property p_nocram;
      cfg_fail |-> !cram_valid;
   endproperty
   a_nocram: assert property (p_nocram) else $error("write in fail");
   property p_stay;
      $fell(cfg_fail) |-> flash_start;
   endproperty
   a_stay: assert property (p_stay) else $error("fail left");
   property p_deny;
      jtag_ir_upd && fuse_jtag_lock && !op_ok |=>
         jtag_denied && jtag_ir_eff == 8'hFF;
   endproperty
   a_deny: assert property (p_deny) else $error("op not refused");
   property p_allow;
      jtag_ir_upd && (op_ok || !fuse_jtag_lock) |=>
         !jtag_denied && jtag_ir_eff == $past(jtag_ir);
   endproperty
   a_allow: assert property (p_allow) else $error("op lost");
   property p_ks;
      ks_take |-> ks_valid && bs_valid && bs_ready;
   endproperty
   a_ks: assert property (p_ks) else $error("bad key take");
   property p_feed;
      feed_valid |-> $past(bs_valid && bs_ready) && feed_data == $past(bs_data);
   endproperty
   a_feed: assert property (p_feed) else $error("bad feed");
   c_user: cover property (user_mode);
   c_fail: cover property ($rose(cfg_fail));
   c_deny: cover property (jtag_denied);
endmodule : sg_chk

bind secure_config_gate sg_chk #(.DW(DW), .IRW(IRW)) u_sg_chk (.*);

// ===== tb/flash_src.sv
`timescale 1ns/100ps
module flash_src (
   // Clock.
   input wire logic clk,
   // Word stream.
   input wire logic flash_start,
   input wire logic bs_ready,
   output logic bs_valid = 1'b0,
   output logic [31:0] bs_data = 32'h0
);
   logic [31:0] mem [0:15];
   int n_words = 0;
   int idx = 99;
   int cyc = 0;
   // Every third cycle stalls; idle data toggles so no stale word shows.
   always @(posedge clk) begin
      cyc++;
      if (flash_start) begin
         idx = 0;
         bs_valid <= 1'b0;
      end else if (bs_valid && !bs_ready) begin
      end else begin
         if (bs_valid) idx++;
         if (idx < n_words && cyc % 3 != 0) begin
            bs_valid <= 1'b1;
            bs_data <= mem[idx];
         end else begin
            bs_valid <= 1'b0;
            bs_data <= ~bs_data;
         end
      end
   end
endmodule : flash_src

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`include "secure_gate_defines.svh"
module tb_top;
   logic clk = 0, sys_rst = 1, cfg_restart_n = 1, fuse_jtag_lock = 0;
   logic [255:0] fuse_key, fuse_key_hash, sig_key_hash, aes_key;
   logic bs_valid, bs_ready, cram_valid, cram_ready = 1, cram_abort;
   logic [31:0] bs_data, cram_data, ks_word = 0, feed_data, reg_wdata = 0;
   logic ks_valid = 1, ks_take, tag_done = 1, tag_ok = 1, flash_start;
   logic sig_done = 1, sig_ok = 1, sig_start, feed_valid, jtag_ir_upd = 0;
   logic [7:0] jtag_ir = 0, jtag_ir_eff, reg_addr = 0;
   logic reg_we = 0, reg_re = 0, jtag_denied, user_mode, cfg_fail;
   logic [31:0] reg_rdata, d, got_q[$], exp_q[$];
   int seed = 32'h721F928D;
   int n_mismatch = 0, checks = 0, n_start = 0, n_sig = 0, i;
   always #10 clk = ~clk;
   secure_config_gate u_secure_config_gate (.*);
   flash_src u_flash_src (.*);
   always @(posedge clk) begin
      if (flash_start) n_start++;
      if (sig_start) n_sig++;
      if (cram_valid && cram_ready) got_q.push_back(cram_data);
      cram_ready <= $random(seed) % 3 != 0;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      reg_addr <= a;
      reg_re <= 1;
      @(posedge clk) reg_re <= 0;
      #1 q = reg_rdata;
      @(posedge clk);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_we <= 1;
      @(posedge clk) reg_we <= 0;
   endtask : wr
   task automatic restart(input int low);
      cfg_restart_n <= 0;
      repeat (low) @(posedge clk);
      cfg_restart_n <= 1;
      @(posedge clk);
   endtask : restart
   task automatic jt(input logic [7:0] op, e, input logic dn);
      jtag_ir <= op;
      jtag_ir_upd <= 1;
      @(posedge clk) jtag_ir_upd <= 0;
      #1 chk(jtag_ir_eff, e);
      chk(jtag_denied, dn);
      @(posedge clk);
   endtask : jt
   function automatic logic exp_user(input logic [2:0] f,
                                     input logic t, s, h);
      return !((f[2] && f[1:0] != 0) || (f[0] && !t) || (f[1] && !(s && h)));
   endfunction : exp_user
   task automatic load(input logic [2:0] f, input logic t, s, h);
      int n, k, s0;
      logic [31:0] w, ks;
      logic eu;
      n = 1 + {$random(seed)} % 8;
      ks = $random(seed);
      ks_word <= ks;
      u_flash_src.mem[0] = {24'(n), 5'h00, f};
      exp_q.delete();
      for (k = 1; k <= n; k++) begin
         w = $random(seed);
         u_flash_src.mem[k] = w;
         exp_q.push_back(f[0] ? w ^ ks : w);
      end
      u_flash_src.n_words = n + 1;
      tag_ok <= t;
      sig_ok <= s;
      sig_key_hash <= h ? fuse_key_hash : ~fuse_key_hash;
      got_q.delete();
      s0 = n_sig;
      restart(60);
      // Let the new state register settle before looking at it.
      @(posedge clk);
      eu = exp_user(f, t, s, h);
      for (k = 0; k < 2000 && !user_mode && !cfg_fail; k++) @(posedge clk);
      chk(user_mode, eu);
      chk(cfg_fail, !eu);
      chk(n_sig - s0, f[1] && !f[2] && !(f[0] && !t));
      if (eu) begin
         chk(got_q.size(), n);
         foreach (exp_q[j]) chk(got_q[j], exp_q[j]);
      end
      rd(`REG_STATUS, d);
      chk(d[7:6], {!eu, eu});
      if (eu) begin
         rd(`REG_WORDS, d);
         chk(d, n);
      end
   endtask : load
   task automatic give_verdict;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   initial begin
      #400000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      fuse_key = {8{$random(seed)}};
      fuse_key_hash = {8{$random(seed)}};
      sig_key_hash = fuse_key_hash;
      repeat (20) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      rd(8'h10, d);
      chk(d, 0);
      chk(aes_key === fuse_key, 1);
      for (i = 0; i < 8; i++) load(i[2:0], 1, 1, 1);
      for (i = 0; i < 12; i++) begin
         d = $random(seed);
         load(d[2:0], d[3], d[4], d[5]);
      end
      load(3'b010, 1, 1, 0);
      load(3'b001, 0, 1, 1);
      rd(`REG_STATUS, d);
      chk(d[8], 1);
      wr(`REG_CTRL, 32'h2);
      rd(`REG_STATUS, d);
      chk(d[8], 0);
      i = n_start;
      restart(10);
      repeat (5) @(posedge clk);
      chk(n_start, i);
      chk(cfg_fail, 1);
      jt(8'h12, 8'h12, 0);
      fuse_jtag_lock <= 1;
      @(posedge clk);
      jt(8'h03, 8'h03, 0);
      jt(8'h05, 8'h05, 0);
      jt(8'h12, 8'hFF, 1);
      jt(8'h00, 8'hFF, 1);
      jt(8'hFF, 8'hFF, 0);
      load(3'b000, 1, 1, 1);
      sys_rst <= 1;
      @(posedge clk) sys_rst <= 0;
      @(posedge clk);
      jt(8'h12, 8'hFF, 1);
      give_verdict();
   end
endmodule : tb_top
